// File: core/ext_start_pin_seq_pkg.sv
package ext_start_pin_seq_pkg;
  // register offsets (word addresses on the plain port)
  localparam logic [3:0] OFF_CTRL   = 4'h0;
  localparam logic [3:0] OFF_CMD    = 4'h1;
  localparam logic [3:0] OFF_DELAY  = 4'h2;
  localparam logic [3:0] OFF_STATUS = 4'h3;
  localparam logic [3:0] OFF_IRQ_ST = 4'h4;
  localparam logic [3:0] OFF_IRQ_MK = 4'h5;
  localparam logic [3:0] OFF_COUNT  = 4'h6;
  // control fields
  localparam int CTRL_REPEAT   = 0;
  localparam int CTRL_EXT_SRC  = 1;
  localparam int CTRL_FALLING  = 2;
  localparam int CTRL_AUTOSEND = 3;
  localparam logic [3:0] CTRL_RESET = 4'h1;
  // command fields (write one to act)
  localparam int CMD_ARM      = 0;
  localparam int CMD_SW_EXT_START_PIN  = 1;
  localparam int CMD_LOCAL    = 2;
  localparam int CMD_MEAS_END = 3;
  // interrupt fields
  localparam int IRQ_EXEC_ERR = 0;
  localparam int IRQ_MEAS_GO  = 1;
  localparam int IRQ_MEAS_END = 2;
  localparam int IRQ_WIDTH    = 3;
  // delay: units of 10 us, 0 .. 0.100 s
  localparam int DELAY_UNIT_NS = 10000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int DELAY_MAX_S_X1000 = 100;
  localparam int DELAY_MAX_UNITS =
    DELAY_MAX_S_X1000 * 1000000 / DELAY_UNIT_NS;
  localparam int UNIT_CYCLES = DELAY_UNIT_NS / CLK_PERIOD_NS;
  localparam int DLY_W = 14;
  localparam int UNIT_W = 10;
  localparam logic [DLY_W-1:0] DELAY_MAX =
    DLY_W'(DELAY_MAX_UNITS);
  localparam logic [UNIT_W-1:0] UNIT_LAST =
    UNIT_W'(UNIT_CYCLES - 1);
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_DELAY = 2'b11,
    ST_MEAS  = 2'b10
  } ext_start_pin_state_e;
endpackage

// File: core/edge_pick.sv
`timescale 1ns/100ps
module edge_pick
  import ext_start_pin_seq_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // pin and polarity
  input  wire logic pin,
  input  wire logic falling,
  // detected edge
  output logic      hit
);
  logic last_reg;
  logic hit_reg;
  wire  rise_w = pin & ~last_reg;
  wire  fall_w = ~pin & last_reg;
  wire  hit_next = falling ? fall_w : rise_w;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      last_reg <= 1'b0;
      hit_reg  <= 1'b0;
    end else begin
      last_reg <= pin;
      hit_reg  <= hit_next;
    end
  end
  assign hit = hit_reg;
endmodule // edge_pick

// File: core/measurement_trigger_sequencer.sv
// Operation
// - with repeat on, every finished measurement goes back to trigger wait.
// - with repeat on and internal origin, triggers follow at once, free run.
// - with repeat off, a finished measurement goes to idle.
// - in idle all triggers are ignored until the block is armed again.
// - the arm command moves idle to trigger wait.
// - arm while repeat is on raises an execution error and changes nothing.
// - internal origin, repeat off: armed block triggers once, then idles.
// - external origin, repeat off: armed block waits, measures once, idles.
// - leaving remote control forces repeat on.
// - repeat accepts one or zero and reads back as on or off.
// - external origin accepts panel key, trigger pin or software trigger.
// - selecting external origin forces auto result sending off.
// - first delay is held from zero to 0.100 s and reads back as stored.
// - host picks rising or falling edge on the trigger pin.
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module measurement_trigger_sequencer
  import ext_start_pin_seq_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // register port
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  // trigger inputs
  input  wire logic        ext_start_pin,
  input  wire logic        panel_start_key,
  // measurement engine
  input  wire logic        meas_done,
  output logic             meas_start,
  output logic             meas_busy,
  // status
  output logic             irq
);
  ext_start_pin_state_e state_reg, state_next;
  logic [3:0]       ctrl_reg, ctrl_next;
  logic [DLY_W-1:0] delay_reg;
  logic [DLY_W-1:0] dcnt_reg, dcnt_next;
  logic [UNIT_W-1:0] ucnt_reg, ucnt_next;
  logic [IRQ_WIDTH-1:0] ist_reg, ist_next;
  logic [IRQ_WIDTH-1:0] imk_reg;
  logic [15:0]      count_reg;
  logic [31:0]      rdata_reg, rdata_next;
  logic             start_reg, busy_reg, irq_reg, key_last_reg;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] o,
                               input logic s);
    hit = s & (a == o);
  endfunction

  // decode
  wire wr_ctrl  = hit(addr, OFF_CTRL, wr);
  wire wr_cmd   = hit(addr, OFF_CMD, wr);
  wire wr_delay = hit(addr, OFF_DELAY, wr);
  wire wr_ist   = hit(addr, OFF_IRQ_ST, wr);
  wire wr_imk   = hit(addr, OFF_IRQ_MK, wr);
  wire cmd_arm  = wr_cmd & wdata[CMD_ARM];
  wire cmd_trg  = wr_cmd & wdata[CMD_SW_EXT_START_PIN];
  wire cmd_loc  = wr_cmd & wdata[CMD_LOCAL];
  wire cmd_end  = wr_cmd & wdata[CMD_MEAS_END];
  wire repeat_measure_setting = ctrl_reg[CTRL_REPEAT];
  wire ext_src  = ctrl_reg[CTRL_EXT_SRC];

  // trigger sources
  wire pin_hit;
  edge_pick u_pin (
    .clk     (clk),
    .rst_b   (rst_b),
    .pin     (ext_start_pin),
    .falling (ctrl_reg[CTRL_FALLING]),
    .hit     (pin_hit)
  );
  wire key_hit  = panel_start_key & ~key_last_reg;
  wire ext_ext_start_pin = pin_hit | key_hit | cmd_trg;
  wire ext_start_pin_go  = ext_src ? ext_ext_start_pin : 1'b1;
  wire done_w   = meas_done | cmd_end;
  wire arm_err  = cmd_arm & repeat_measure_setting;
  wire arm_ok   = cmd_arm & ~repeat_measure_setting;

  // control register next value
  logic [3:0] ctrl_wr;
  always_comb begin
    ctrl_wr = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_wr = wdata[3:0];
    end
    if (ctrl_wr[CTRL_EXT_SRC]) begin
      ctrl_wr[CTRL_AUTOSEND] = 1'b0;
    end
    if (cmd_loc) begin
      ctrl_wr[CTRL_REPEAT] = 1'b1;
    end
    ctrl_next = ctrl_wr;
  end

  // state machine
  wire delay_zero = (delay_reg == '0);
  always_comb begin
    state_next = state_reg;
    dcnt_next  = dcnt_reg;
    ucnt_next  = ucnt_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (arm_ok) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (ext_start_pin_go) begin
          dcnt_next  = delay_reg;
          ucnt_next  = UNIT_LAST;
          state_next = delay_zero ? ST_MEAS : ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (ucnt_reg != '0) begin
          ucnt_next = ucnt_reg - 1'b1;
        end else if (dcnt_reg == 14'h0001) begin
          state_next = ST_MEAS;
        end else begin
          ucnt_next = UNIT_LAST;
          dcnt_next = dcnt_reg - 1'b1;
        end
      end
      ST_MEAS: begin
        if (done_w) begin
          state_next = repeat_measure_setting ? ST_WAIT
                                              : ST_IDLE;
        end
      end
    endcase
  end
  wire enter_meas = (state_next == ST_MEAS) & (state_reg != ST_MEAS);
  wire leave_meas = (state_reg == ST_MEAS) & done_w;

  // interrupts
  wire [IRQ_WIDTH-1:0] ev = {leave_meas, enter_meas, arm_err};
  wire [IRQ_WIDTH-1:0] ist_clr = wr_ist ? wdata[IRQ_WIDTH-1:0] : '0;
  assign ist_next = (ist_reg & ~ist_clr) | ev;

  // read mux
  wire [DLY_W-1:0] wdly = wdata[DLY_W-1:0];
  wire dly_ok = (wdata[31:DLY_W] == '0) & (wdly <= DELAY_MAX);
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (rd) begin
      unique case (addr)
        OFF_CTRL:   rdata_next = {28'h0, ctrl_reg};
        OFF_DELAY:  rdata_next = {18'h0, delay_reg};
        OFF_STATUS: rdata_next = {30'h0, state_reg};
        OFF_IRQ_ST: rdata_next = {29'h0, ist_reg};
        OFF_IRQ_MK: rdata_next = {29'h0, imk_reg};
        OFF_COUNT:  rdata_next = {16'h0, count_reg};
        default:    rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_WAIT;
      ctrl_reg  <= CTRL_RESET;
      delay_reg <= '0;
      dcnt_reg  <= '0;
      ucnt_reg  <= '0;
      ist_reg   <= '0;
      imk_reg   <= '0;
      count_reg <= '0;
      rdata_reg <= '0;
      start_reg <= 1'b0;
      busy_reg  <= 1'b0;
      irq_reg   <= 1'b0;
      key_last_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ctrl_reg  <= ctrl_next;
      if (wr_delay && dly_ok) begin
        delay_reg <= wdly;
      end
      dcnt_reg  <= dcnt_next;
      ucnt_reg  <= ucnt_next;
      ist_reg   <= ist_next;
      if (wr_imk) begin
        imk_reg <= wdata[IRQ_WIDTH-1:0];
      end
      if (enter_meas) begin
        count_reg <= count_reg + 16'h0001;
      end
      rdata_reg <= rdata_next;
      start_reg <= enter_meas;
      busy_reg  <= (state_next == ST_MEAS);
      irq_reg   <= |(ist_next & imk_reg);
      key_last_reg <= panel_start_key;
    end
  end

  assign rdata      = rdata_reg;
  assign meas_start = start_reg;
  assign meas_busy  = busy_reg;
  assign irq        = irq_reg;
endmodule // measurement_trigger_sequencer

// File: testbench/meas_engine.sv
`timescale 1ns/100ps
module meas_engine (
  // clock, reset and handshake
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       meas_start,
  input  wire logic [7:0] lat,
  output logic            meas_done
);
  logic [7:0] cnt_reg;
  logic       run_reg;
  // answers each start with one done pulse lat + 2 cycles after the start pulse
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {run_reg, cnt_reg, meas_done} <= '0;
    end else begin
      meas_done <= run_reg && cnt_reg == 8'h0;
      run_reg   <= meas_start || (run_reg && cnt_reg != 8'h0);
      cnt_reg   <= meas_start ? lat : cnt_reg - 8'h1;
    end
  end
endmodule // meas_engine

// File: testbench/ext_start_pin_seq_monitor.sv
`timescale 1ns/100ps
module ext_start_pin_seq_monitor
  import ext_start_pin_seq_pkg::*;
(
  // clock, reset and register port
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [3:0]  addr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  // measurement engine
  input wire logic        meas_done,
  input wire logic        meas_start,
  input wire logic        meas_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence end_s; meas_busy && meas_done; endsequence
  sequence rd_s(a); rd && addr == a; endsequence
  start_once_a: assert property (meas_start |=> !meas_start)
    else $error("long start");
  busy_follow_a: assert property (meas_start |-> ##[0:1] meas_busy)
    else $error("no busy");
  busy_hold_a: assert property (meas_busy && !meas_done |=> meas_busy)
    else $error("busy dropped");
  end_leave_a: assert property (end_s |-> ##[1:2] !meas_busy)
    else $error("busy stuck");
  busy_quiet_a: assert property (
    $past(meas_busy) && meas_busy && !meas_done && !$past(meas_done)
    |=> !meas_start) else $error("start while busy");
  ctrl_read_a: assert property (
    rd_s(OFF_CTRL) |=> !(rdata[1] && rdata[3])) else $error("autosend");
  delay_max_a: assert property (
    rd_s(OFF_DELAY) |=> rdata <= 32'h2710) else $error("delay range");
  state_code_a: assert property (
    rd_s(OFF_STATUS) |=> rdata[31:2] == 30'h0) else $error("state code");
endmodule // ext_start_pin_seq_monitor
bind measurement_trigger_sequencer ext_start_pin_seq_monitor mon (.clk(clk),
  .rst_b(rst_b), .addr(addr), .rd(rd), .rdata(rdata), .meas_done(meas_done),
  .meas_start(meas_start), .meas_busy(meas_busy));

// File: testbench/tb.sv
`timescale 1ns/100ps
module tb;
  import ext_start_pin_seq_pkg::*;
  logic        clk = 0, rst_b = 0, wr = 0, rd = 0;
  logic        ext_start_pin = 0, panel_start_key = 0;
  logic        meas_done, meas_start, meas_busy, irq;
  logic [3:0]  addr = 0;
  logic [31:0] wdata = 0, rdata, got;
  logic [7:0]  lat = 0;
  int          fails, checks, starts, base, k, d;
  always #5 clk = ~clk;
  always @(posedge clk) if (meas_start === 1'b1) starts <= starts + 1;
  measurement_trigger_sequencer dut (.*);
  meas_engine eng (.*);
  task automatic final_report;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic ok);
    checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("mismatch at %0t: differs from model", $time);
    end
  endtask
  task automatic bus(input logic [3:0] a, input logic [31:0] v, logic w);
    @(posedge clk);
    addr <= a; wdata <= v; wr <= w; rd <= !w;
    @(posedge clk);
    wr <= 1'b0; rd <= 1'b0;
    #1 got = rdata;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] v);
    bus(a, 32'h0, 1'b0);
    chk(got === v);
  endtask
  // waits until the engine is quiet, then compares the start count
  task automatic run(input int n);
    for (k = 0; k < 4000 && (k < 40 || meas_busy !== 1'b0); k++)
      @(negedge clk);
    if (n >= 0) chk(starts - base == n);
    base = starts;
    lat = 8'($urandom % 16);
  endtask
  // key rising, pin toggle or software trigger
  task automatic hit(input int s);
    if (s == 2) bus(OFF_CMD, 32'h2, 1'b1);
    else begin
      @(posedge clk);
      if (s == 0) panel_start_key <= 1'b1;
      else ext_start_pin <= !ext_start_pin;
      repeat (3) @(posedge clk);
      panel_start_key <= 1'b0;
    end
  endtask
  initial begin
    #1000000;
    fails++;
    final_report();
  end
  initial begin
    lat = 8'($urandom(82) % 16);
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rdc(OFF_CTRL, 32'h1);
    run(-1);
    chk(base >= 2);
    bus(OFF_CTRL, 32'h0, 1'b1);
    run(-1);
    rdc(OFF_STATUS, 32'h0);
    for (d = 0; d < 4; d++) hit(d[0] ? 1 : d);
    run(0);
    bus(OFF_CMD, 32'h1, 1'b1);
    run(1);
    rdc(OFF_STATUS, 32'h0);
    bus(OFF_CTRL, 32'ha, 1'b1);
    rdc(OFF_CTRL, 32'h2);
    for (d = 0; d < 4; d++) begin
      if (d == 3) bus(OFF_CTRL, 32'h6, 1'b1);
      bus(OFF_CMD, 32'h1, 1'b1);
      rdc(OFF_STATUS, 32'h1);
      hit(d == 3 ? 1 : d);
      run(1);
      rdc(OFF_STATUS, 32'h0);
    end
    bus(OFF_CTRL, 32'h2, 1'b1);
    bus(OFF_CMD, 32'h1, 1'b1);
    bus(OFF_CTRL, 32'h3, 1'b1);
    bus(OFF_IRQ_MK, 32'h1, 1'b1);
    bus(OFF_CMD, 32'h1, 1'b1);
    @(posedge clk);
    #1 chk(irq === 1'b1);
    rdc(OFF_STATUS, 32'h1);
    bus(OFF_IRQ_ST, 32'h1, 1'b1);
    @(posedge clk);
    #1 chk(irq === 1'b0);
    hit(2);
    run(1);
    rdc(OFF_STATUS, 32'h1);
    bus(OFF_CTRL, 32'h2, 1'b1);
    bus(OFF_CMD, 32'h4, 1'b1);
    rdc(OFF_CTRL, 32'h3);
    bus(OFF_DELAY, 32'h2711, 1'b1);
    rdc(OFF_DELAY, 32'h0);
    d = 1 + $urandom % 2;
    bus(OFF_DELAY, 32'(d), 1'b1);
    rdc(OFF_DELAY, 32'(d));
    bus(OFF_CTRL, 32'h0, 1'b1);
    for (k = 0; k < 2500 && meas_start !== 1'b1; k++) @(negedge clk);
    chk(k >= d * 1000 && k < d * 1000 + 8);
    run(1);
    rdc(4'hf, 32'h0);
    final_report();
  end
endmodule // tb
